//--- bench/pso_host_model.sv
// register port model of the external controller
`timescale 1ns/1ns
module pso_host_model (
	input wire logic clk,
	input wire logic [7:0] regRdata,
	input wire logic regRvalid,
	output logic [7:0] regAddr,
	output logic regWrite,
	output logic regRead,
	output logic [7:0] regWdata
);
	initial begin
		regAddr = 8'h00;
		regWdata = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
	end
	// ==========================================================
	// strobes open one edge after the call, so calls never collide
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		regAddr = a;
		regWdata = d;
		regWrite = 1'b1;
		@(posedge clk);
		#1;
		regWrite = 1'b0;
		regAddr = ~a;
		regWdata = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge clk);
		#1;
		regAddr = a;
		regRead = 1'b1;
		@(posedge clk);
		#1;
		regRead = 1'b0;
		regAddr = ~a;
		v = regRvalid;
		d = regRdata;
	endtask : rd
endmodule : pso_host_model

//--- bench/pso_setup_options_bench.sv
// self-checking bench of the setup option block
`timescale 1ns/1ns
module pso_setup_options_bench;
	logic clk, rst, regWrite, regRead, regRvalid;
	logic [7:0] regAddr, regWdata, regRdata;
	logic cf, ow, chg, dch, uv, ov, lk, bl, lv, wk, eoc, dem, l1, l2, cr, dr, sc;
	logic pack_shutdown_output, charge_fet_drive, pfet, discharge_fet_drive, bal, scan, pd, fm;
	logic [1:0] gain;
	int fails = 0;
	int checked = 0;
	pso_host_model host (.clk(clk), .regRdata(regRdata), .regRvalid(regRvalid),
		.regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata));
	pso_setup_options pso_setup_options_inst (.clk(clk), .rst(rst), .regAddr(regAddr),
		.regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
		.regRvalid(regRvalid), .cellFailFlag(cf), .openWireDetected(ow),
		.chargeCurrentDetected(chg), .dischargeCurrentDetected(dch), .cellUndervoltageFlag(uv),
		.cellOvervoltageFlag(ov), .lockoutFlag(lk), .cellBelowLockout(bl),
		.cellBelowLowVoltageCharge(lv), .chargerWake(wk), .endOfChargeFlag(eoc),
		.balanceDemand(dem), .firstThermistorBalanceLimit(l1),
		.secondThermistorBalanceLimit(l2), .chargeFetRequest(cr), .dischargeFetRequest(dr),
		.shutdownClear(sc), .packShutdownOutput(pack_shutdown_output), .chargeFetDrive(charge_fet_drive),
		.prechargeFetDrive(pfet), .dischargeFetDrive(discharge_fet_drive), .balanceEnable(bal),
		.openWireScanStart(scan), .powerDownActive(pd), .secondThermistorFetMode(fm),
		.temperatureGain(gain));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// ==========================================================
	// helpers
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic ck(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask : ck
	task automatic cb(input logic g, input logic e);
		ck({7'h00, g}, {7'h00, e});
	endtask : cb
	task automatic rk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic v;
		host.rd(a, d, v);
		cb(v, 1'b1);
		ck(d, e);
	endtask : rk
	task automatic conclude();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	// ==========================================================
	// scenarios
	task automatic t_regs();
		rk(8'h4a, 8'h00);
		rk(8'h4b, 8'h40);
		ck({6'h00, gain}, 8'h02);
		host.wr(8'h4a, 8'hff);
		host.wr(8'h4b, 8'hff);
		rk(8'h4a, 8'hb7);
		rk(8'h4b, 8'hf9);
		ck({6'h00, gain}, 8'h01);
		cb(fm, 1'b1);
		host.wr(8'h4c, 8'h5a);
		host.wr(8'h50, 8'ha5);
		host.wr(8'h58, 8'h33);
		rk(8'h4c, 8'h00);
		rk(8'h50, 8'ha5);
		rk(8'h58, 8'h00);
		host.wr(8'h4a, 8'h00);
		host.wr(8'h4b, 8'h40);
	endtask : t_regs
	task automatic clr();
		sc = 1'b1;
		step(1);
		sc = 1'b0;
		step(1);
		cb(pack_shutdown_output, 1'b0);
	endtask : clr
	task automatic t_fail();
		cf = 1'b1;
		step(1);
		cb(scan, 1'b1);
		step(1);
		cb(pack_shutdown_output, 1'b0);
		cf = 1'b0;
		host.wr(8'h4a, 8'h82);
		cf = 1'b1;
		step(1);
		cb(pack_shutdown_output, 1'b1);
		cb(scan, 1'b0);
		cf = 1'b0;
		clr();
		host.wr(8'h4a, 8'h00);
		ow = 1'b1;
		step(2);
		cb(pack_shutdown_output, 1'b0);
		host.wr(8'h4a, 8'h01);
		step(1);
		cb(pack_shutdown_output, 1'b1);
		ow = 1'b0;
		clr();
	endtask : t_fail
	task automatic t_fet();
		host.wr(8'h4a, 8'h04);
		lv = 1'b1;
		step(2);
		cb(pfet, 1'b1);
		cb(charge_fet_drive, 1'b0);
		lv = 1'b0;
		host.wr(8'h4a, 8'h00);
		ov = 1'b1;
		uv = 1'b1;
		step(2);
		cb(charge_fet_drive, 1'b0);
		cb(discharge_fet_drive, 1'b0);
		host.wr(8'h4b, 8'h70);
		chg = 1'b1;
		step(2);
		cb(discharge_fet_drive, 1'b1);
		cb(charge_fet_drive, 1'b0);
		chg = 1'b0;
		dch = 1'b1;
		step(2);
		cb(discharge_fet_drive, 1'b0);
		cb(charge_fet_drive, 1'b1);
		{ov, uv, dch} = 3'h0;
	endtask : t_fet
	task automatic t_bal();
		dem = 1'b1;
		host.wr(8'h4b, 8'h40);
		chg = 1'b1;
		step(2);
		cb(bal, 1'b1);
		chg = 1'b0;
		dch = 1'b1;
		step(2);
		cb(bal, 1'b0);
		host.wr(8'h4b, 8'h80);
		step(1);
		cb(bal, 1'b1);
		host.wr(8'h4b, 8'h00);
		step(1);
		cb(bal, 1'b0);
		dch = 1'b0;
		eoc = 1'b1;
		host.wr(8'h4b, 8'h41);
		step(1);
		cb(bal, 1'b1);
		host.wr(8'h4b, 8'h40);
		step(1);
		cb(bal, 1'b0);
		host.wr(8'h4b, 8'h41);
		host.wr(8'h4a, 8'h20);
		l2 = 1'b1;
		step(2);
		cb(bal, 1'b1);
		l1 = 1'b1;
		step(2);
		cb(bal, 1'b0);
		l1 = 1'b0;
		host.wr(8'h4a, 8'h00);
		step(1);
		cb(bal, 1'b0);
		{dem, eoc, l1, l2} = 4'h0;
	endtask : t_bal
	task automatic t_pwr();
		lk = 1'b1;
		step(2);
		cb(pd, 1'b0);
		lk = 1'b0;
		host.wr(8'h4b, 8'h48);
		lk = 1'b1;
		step(1);
		cb(pd, 1'b1);
		cb(discharge_fet_drive, 1'b0);
		bl = 1'b1;
		repeat (2) begin
			wk = 1'b1;
			step(1);
			wk = 1'b0;
			step(2);
			cb(pd, bl);
			bl = 1'b0;
		end
	endtask : t_pwr
	initial begin
		rst = 1'b1;
		{cf, ow, chg, dch, uv, ov, lk, bl, lv, wk, eoc, dem, l1, l2, sc} = 15'h0000;
		{cr, dr} = 2'h3;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		t_regs();
		t_fail();
		t_fet();
		t_bal();
		t_pwr();
		conclude();
	end
endmodule : pso_setup_options_bench

//--- bench/pso_setup_options_sva.sv
// assertion checker for the setup option registers and their effects
`timescale 1ns/1ns
module pso_setup_options_sva (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] regAddr,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regWdata,
	input wire logic [7:0] regRdata,
	input wire logic regRvalid,
	input wire logic cellFailFlag,
	input wire logic openWireDetected,
	input wire logic chargeCurrentDetected,
	input wire logic dischargeCurrentDetected,
	input wire logic cellUndervoltageFlag,
	input wire logic cellOvervoltageFlag,
	input wire logic lockoutFlag,
	input wire logic cellBelowLowVoltageCharge,
	input wire logic endOfChargeFlag,
	input wire logic packShutdownOutput,
	input wire logic chargeFetDrive,
	input wire logic dischargeFetDrive,
	input wire logic balanceEnable,
	input wire logic openWireScanStart,
	input wire logic powerDownActive,
	input wire logic secondThermistorFetMode,
	input wire logic [1:0] temperatureGain
);
	logic [7:0] sh0_r;
	logic [7:0] sh1_r;
	// ==========================================================
	// shadows of the setup registers, raw write data kept
	always_ff @(posedge clk) begin
		if (rst) begin
			sh0_r <= 8'h00;
			sh1_r <= 8'h40;
		end else if (regWrite && regAddr == 8'h4a) sh0_r <= regWdata;
		else if (regWrite && regAddr == 8'h4b) sh1_r <= regWdata;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ==========================================================
	// properties
	a_read_mask: assert property (regRead && regAddr == 8'h4a |=> regRvalid &&
		regRdata == ($past(sh0_r) & 8'hb7)) else $error("setup read data wrong");
	a_fail_shut: assert property (cellFailFlag && sh0_r[7] |=> packShutdownOutput)
		else $error("no shutdown on cell fail");
	a_fet_mode: assert property (sh0_r[5] |=> secondThermistorFetMode)
		else $error("fet mode not set");
	a_gain_one: assert property (sh0_r[4] |=> temperatureGain == 2'h1)
		else $error("gain not one");
	a_pre_swap: assert property (sh0_r[2] && cellBelowLowVoltageCharge |=> !chargeFetDrive)
		else $error("charge fet on in precharge");
	a_scan_go: assert property ($rose(cellFailFlag) && !sh0_r[1] |=> openWireScanStart)
		else $error("no open wire scan");
	a_scan_off: assert property (sh0_r[1] |=> !openWireScanStart)
		else $error("scan while disabled");
	a_wire_shut: assert property (openWireDetected && sh0_r[0] |=> packShutdownOutput)
		else $error("no shutdown on open wire");
	a_bal_cause: assert property (!(sh1_r[6] && chargeCurrentDetected ||
		sh1_r[7] && dischargeCurrentDetected || sh1_r[0] && endOfChargeFlag) |=> !balanceEnable)
		else $error("balance without cause");
	a_bal_none: assert property (!sh1_r[7] && !sh1_r[6] |=> !balanceEnable)
		else $error("balance with both bits clear");
	a_uv_discharge_fet_drive: assert property (cellUndervoltageFlag &&
		(!sh1_r[5] || dischargeCurrentDetected) |=> !dischargeFetDrive) else $error("discharge_fet_drive on in uv");
	a_ov_charge_fet_drive: assert property (cellOvervoltageFlag &&
		(!sh1_r[4] || chargeCurrentDetected) |=> !chargeFetDrive) else $error("charge_fet_drive on in ov");
	a_lock_down: assert property ($rose(lockoutFlag) && sh1_r[3] |=> powerDownActive)
		else $error("no power down on lockout");
endmodule : pso_setup_options_sva

bind pso_setup_options pso_setup_options_sva pso_setup_options_sva_inst (.clk, .rst, .regAddr,
	.regWrite, .regRead, .regWdata, .regRdata, .regRvalid, .cellFailFlag, .openWireDetected,
	.chargeCurrentDetected, .dischargeCurrentDetected, .cellUndervoltageFlag,
	.cellOvervoltageFlag, .lockoutFlag, .cellBelowLowVoltageCharge, .endOfChargeFlag,
	.packShutdownOutput, .chargeFetDrive, .dischargeFetDrive, .balanceEnable,
	.openWireScanStart, .powerDownActive, .secondThermistorFetMode, .temperatureGain);

//--- inc/pso_pkg.sv
// constants and types shared by the pack protection setup option block
package pso_pkg;

	// ==========================================================
	// register map
	localparam logic [7:0] PSO_ADDR_SETUP_FIRST = 8'h4a;
	localparam logic [7:0] PSO_ADDR_SETUP_SECOND = 8'h4b;
	localparam logic [7:0] PSO_ADDR_RSVD_LOW_FIRST = 8'h4c;
	localparam logic [7:0] PSO_ADDR_USER_FIRST = 8'h50;
	localparam logic [7:0] PSO_ADDR_USER_LAST = 8'h57;
	localparam logic [7:0] PSO_ADDR_RSVD_HIGH_FIRST = 8'h58;
	localparam int PSO_USER_DEPTH = 8;
	localparam int PSO_USER_IDX_W = 3;

	// ==========================================================
	// reset values and writable bit masks
	localparam logic [7:0] PSO_SETUP_FIRST_RST = 8'h00;
	localparam logic [7:0] PSO_SETUP_SECOND_RST = 8'h40;
	localparam logic [7:0] PSO_USER_RST = 8'h00;
	localparam logic [7:0] PSO_SETUP_FIRST_MASK = 8'hb7;
	localparam logic [7:0] PSO_SETUP_SECOND_MASK = 8'hf9;

	// ==========================================================
	// field positions, first setup register
	localparam int PSO_CELL_FAIL_SHUTDOWN_ENABLE = 7;
	localparam int PSO_SECOND_THERMISTOR_FUNCTION = 5;
	localparam int PSO_TEMPERATURE_GAIN_SELECT = 4;
	localparam int PSO_PRECHARGE_FET_ENABLE = 2;
	localparam int PSO_OPEN_WIRE_SCAN_DISABLE = 1;
	localparam int PSO_OPEN_WIRE_SHUTDOWN_ENABLE = 0;

	// field positions, second setup register
	localparam int PSO_BALANCE_IN_DISCHARGE = 7;
	localparam int PSO_BALANCE_IN_CHARGE = 6;
	localparam int PSO_DISCHARGE_FET_HOLD_BIT = 5;
	localparam int PSO_CHARGE_FET_HOLD_BIT = 4;
	localparam int PSO_LOCKOUT_POWERDOWN_ENABLE = 3;
	localparam int PSO_BALANCE_AFTER_FULL_CHARGE = 0;

	// measurement gains selected by the temperature gain bit
	localparam logic [1:0] PSO_GAIN_LOW_SETTING = 2'h2;
	localparam logic [1:0] PSO_GAIN_HIGH_SETTING = 2'h1;

	// ==========================================================
	// power state
	typedef enum logic [1:0] {
		PSO_RUN = 2'b00,
		PSO_POWERDOWN = 2'b01,
		PSO_WAKE_CHECK = 2'b10
	} pso_power_e;

endpackage : pso_pkg

//--- logic/pso_setup_options.sv
// setup option registers and the protection decisions they steer
`timescale 1ns/1ns
// What this block does
// - reserved bits of both setup registers are stored as zero and read back as zero.
// - with cell-fail shutdown enabled, a cell-fail detection asserts the pack shutdown output.
// - with the second thermistor set as a FET sensor, its readings never stop balancing.
// - the gain bit selects a temperature gain of 2 when clear and 1 when set.
// - with pre-charge enabled and a cell below the low charge level, pre-charge replaces charge.
// - a cell-fail detection starts an open-wire scan unless the scan disable bit is set.
// - with open-wire shutdown enabled, an open-wire detection asserts pack shutdown.
// - balancing in discharge needs the discharge bit and discharge current.
// - balancing in charge needs the charge bit and charge current.
// - with both balance direction bits clear, automatic balancing is off entirely.
// - with the discharge hold bit clear, undervoltage turns the discharge FET off.
// - with that bit set, undervoltage leaves the discharge FET on only while charging.
// - with the charge hold bit clear, overvoltage turns the charge FET off.
// - with that bit set, overvoltage leaves the charge FET on only while discharging.
// - with lockout power-down enabled, setting the lockout flag powers the device down.
// - after a charger wake, a cell still under lockout sends the device back to power-down.
// - the end-of-charge bit lets balancing after full charge run with no current flowing.
module pso_setup_options
	import pso_pkg::*;
#(
	parameter int USER_DEPTH = PSO_USER_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] regAddr,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	output logic regRvalid,
	input wire logic cellFailFlag,
	input wire logic openWireDetected,
	input wire logic chargeCurrentDetected,
	input wire logic dischargeCurrentDetected,
	input wire logic cellUndervoltageFlag,
	input wire logic cellOvervoltageFlag,
	input wire logic lockoutFlag,
	input wire logic cellBelowLockout,
	input wire logic cellBelowLowVoltageCharge,
	input wire logic chargerWake,
	input wire logic endOfChargeFlag,
	input wire logic balanceDemand,
	input wire logic firstThermistorBalanceLimit,
	input wire logic secondThermistorBalanceLimit,
	input wire logic chargeFetRequest,
	input wire logic dischargeFetRequest,
	input wire logic shutdownClear,
	output logic packShutdownOutput,
	output logic chargeFetDrive,
	output logic prechargeFetDrive,
	output logic dischargeFetDrive,
	output logic balanceEnable,
	output logic openWireScanStart,
	output logic powerDownActive,
	output logic secondThermistorFetMode,
	output logic [1:0] temperatureGain
);

	import pso_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		logic [7:0] setupFirst;
		logic [7:0] setupSecond;
		// user bytes are plain flip-flops; keeping them over power loss is left to the device
		logic [USER_DEPTH-1:0][7:0] userMem;
		logic [7:0] rdata;
		logic rvalid;
		logic cellFailSeen;
		logic lockoutSeen;
		pso_power_e power;
		logic powerDown;
		logic shutdown;
		logic chargeFet;
		logic prechargeFet;
		logic dischargeFet;
		logic balance;
		logic scanStart;
		logic fetMode;
		logic [1:0] gain;
	} pso_state_s;

	pso_state_s state_r;
	pso_state_s state_nxt;

	// ==========================================================
	// helpers
	function automatic logic pso_in_user(input logic [7:0] addr);
		pso_in_user = (addr >= PSO_ADDR_USER_FIRST) && (addr <= PSO_ADDR_USER_LAST);
	endfunction : pso_in_user

	// only the low bits of the offset matter once the range test has passed
	function automatic logic [PSO_USER_IDX_W-1:0] pso_user_idx(input logic [7:0] addr);
		logic [7:0] off;
		off = addr - PSO_ADDR_USER_FIRST;
		pso_user_idx = off[PSO_USER_IDX_W-1:0];
	endfunction : pso_user_idx

	// a hold bit keeps its FET on only while current flows the way that relieves the fault;
	// current the other way, or none at all, still forces the FET off
	function automatic logic pso_fet_block(
		input logic fault,
		input logic holdBit,
		input logic relievingFlow,
		input logic worseningFlow
	);
		pso_fet_block = fault && (!holdBit || !relievingFlow || worseningFlow);
	endfunction : pso_fet_block

	// reserved bits are cleared on the way in and again on the way out,
	// so a zero read back never depends on what the host wrote into them
	function automatic logic [7:0] pso_clear_reserved(input logic [7:0] data,
		input logic [7:0] keep);
		pso_clear_reserved = data & keep;
	endfunction : pso_clear_reserved

	// ==========================================================
	// decoded option bits
	logic cellFailShutdownEnable;
	logic secondThermistorFunction;
	logic temperatureGainSelect;
	logic prechargeFetEnable;
	logic openWireScanDisable;
	logic openWireShutdownEnable;
	logic balanceInDischarge;
	logic balanceInCharge;
	logic dischargeFetHoldBit;
	logic chargeFetHoldBit;
	logic lockoutPowerdownEnable;
	logic balanceAfterFullCharge;

	assign cellFailShutdownEnable = state_r.setupFirst[PSO_CELL_FAIL_SHUTDOWN_ENABLE];
	assign secondThermistorFunction = state_r.setupFirst[PSO_SECOND_THERMISTOR_FUNCTION];
	assign temperatureGainSelect = state_r.setupFirst[PSO_TEMPERATURE_GAIN_SELECT];
	assign prechargeFetEnable = state_r.setupFirst[PSO_PRECHARGE_FET_ENABLE];
	assign openWireScanDisable = state_r.setupFirst[PSO_OPEN_WIRE_SCAN_DISABLE];
	assign openWireShutdownEnable = state_r.setupFirst[PSO_OPEN_WIRE_SHUTDOWN_ENABLE];
	assign balanceInDischarge = state_r.setupSecond[PSO_BALANCE_IN_DISCHARGE];
	assign balanceInCharge = state_r.setupSecond[PSO_BALANCE_IN_CHARGE];
	assign dischargeFetHoldBit = state_r.setupSecond[PSO_DISCHARGE_FET_HOLD_BIT];
	assign chargeFetHoldBit = state_r.setupSecond[PSO_CHARGE_FET_HOLD_BIT];
	assign lockoutPowerdownEnable = state_r.setupSecond[PSO_LOCKOUT_POWERDOWN_ENABLE];
	assign balanceAfterFullCharge = state_r.setupSecond[PSO_BALANCE_AFTER_FULL_CHARGE];

	// ==========================================================
	// next state
	always_comb begin
		logic cellFailRise;
		logic lockoutRise;
		logic dischargeBlock;
		logic chargeBlock;
		logic chargeAllowed;
		logic dischargeAllowed;
		logic tempLimit;
		logic directionOk;
		logic autoBalance;
		logic usePrecharge;
		logic powered;
		logic fetsAllowed;
		cellFailRise = 1'b0;
		lockoutRise = 1'b0;
		dischargeBlock = 1'b0;
		chargeBlock = 1'b0;
		chargeAllowed = 1'b0;
		dischargeAllowed = 1'b0;
		tempLimit = 1'b0;
		directionOk = 1'b0;
		autoBalance = 1'b0;
		usePrecharge = 1'b0;
		powered = 1'b0;
		fetsAllowed = 1'b0;
		// every field holds unless a line below says otherwise
		state_nxt = state_r;

		// register writes; reserved bits never take a one
		if (regWrite) begin
			case (regAddr)
				PSO_ADDR_SETUP_FIRST: begin
					state_nxt.setupFirst = pso_clear_reserved(regWdata, PSO_SETUP_FIRST_MASK);
				end
				PSO_ADDR_SETUP_SECOND: begin
					state_nxt.setupSecond = pso_clear_reserved(regWdata,
						PSO_SETUP_SECOND_MASK);
				end
				default: begin
					if (pso_in_user(regAddr)) begin
						state_nxt.userMem[pso_user_idx(regAddr)] = regWdata;
					end
				end
			endcase
		end

		// reads answer one cycle later; reserved and unmapped read zero
		// rdata holds its value between reads, so a slow look still finds the answer
		state_nxt.rvalid = regRead;
		if (regRead) begin
			case (regAddr)
				PSO_ADDR_SETUP_FIRST: begin
					state_nxt.rdata = pso_clear_reserved(state_r.setupFirst,
						PSO_SETUP_FIRST_MASK);
				end
				PSO_ADDR_SETUP_SECOND: begin
					state_nxt.rdata = pso_clear_reserved(state_r.setupSecond,
						PSO_SETUP_SECOND_MASK);
				end
				default: begin
					if (pso_in_user(regAddr)) begin
						state_nxt.rdata = state_r.userMem[pso_user_idx(regAddr)];
					end else begin
						state_nxt.rdata = 8'h00;
					end
				end
			endcase
		end

		// event detection on flag edges
		// the seen flags reset low, the idle level of both flags, so reset makes no false edge
		cellFailRise = cellFailFlag && !state_r.cellFailSeen;
		lockoutRise = lockoutFlag && !state_r.lockoutSeen;
		state_nxt.cellFailSeen = cellFailFlag;
		state_nxt.lockoutSeen = lockoutFlag;

		// one scan per new cell-fail detection, not per cycle of the flag
		state_nxt.scanStart = cellFailRise && !openWireScanDisable;

		// shutdown latches; only an explicit clear releases it, and a new cause wins
		if (shutdownClear) begin
			state_nxt.shutdown = 1'b0;
		end
		if (cellFailFlag && cellFailShutdownEnable) begin
			state_nxt.shutdown = 1'b1;
		end
		if (openWireDetected && openWireShutdownEnable) begin
			state_nxt.shutdown = 1'b1;
		end

		// power state
		case (state_r.power)
			PSO_RUN: begin
				// entered on the rise only, so a flag that stays set lets a wake succeed
				if (lockoutRise && lockoutPowerdownEnable) begin
					state_nxt.power = PSO_POWERDOWN;
				end
			end
			PSO_POWERDOWN: begin
				// only a charger connection wakes the block, for a check of one cycle
				if (chargerWake) begin
					state_nxt.power = PSO_WAKE_CHECK;
				end
			end
			PSO_WAKE_CHECK: begin
				// a lockout flag raised during the check sends the block down as well
				if (lockoutPowerdownEnable && (cellBelowLockout || lockoutRise)) begin
					state_nxt.power = PSO_POWERDOWN;
				end else begin
					state_nxt.power = PSO_RUN;
				end
			end
			default: begin
				state_nxt.power = PSO_RUN;
			end
		endcase
		powered = (state_nxt.power == PSO_RUN);
		// kept as a flip-flop of its own so the output needs no gate behind the register
		state_nxt.powerDown = (state_nxt.power != PSO_RUN);

		// undervoltage hold only helps while charge flows and discharge does not
		dischargeBlock = pso_fet_block(cellUndervoltageFlag, dischargeFetHoldBit,
			chargeCurrentDetected, dischargeCurrentDetected);
		// overvoltage hold only helps while discharge flows and charge does not
		chargeBlock = pso_fet_block(cellOvervoltageFlag, chargeFetHoldBit,
			dischargeCurrentDetected, chargeCurrentDetected);
		// power-down and a latched shutdown both force every FET off, whatever is requested
		fetsAllowed = powered && !state_nxt.shutdown;
		dischargeAllowed = fetsAllowed && dischargeFetRequest && !dischargeBlock;
		chargeAllowed = fetsAllowed && chargeFetRequest && !chargeBlock;
		// pre-charge only changes which FET carries the charge request; it never adds one
		usePrecharge = prechargeFetEnable && cellBelowLowVoltageCharge;
		state_nxt.dischargeFet = dischargeAllowed;
		state_nxt.chargeFet = chargeAllowed && !usePrecharge;
		state_nxt.prechargeFet = chargeAllowed && usePrecharge;

		// balancing
		tempLimit = firstThermistorBalanceLimit ||
			(secondThermistorBalanceLimit && !secondThermistorFunction);
		// end-of-charge balancing skips the direction test but not the global enable
		directionOk = (balanceInCharge && chargeCurrentDetected) ||
			(balanceInDischarge && dischargeCurrentDetected) ||
			(endOfChargeFlag && balanceAfterFullCharge);
		autoBalance = balanceInCharge || balanceInDischarge;
		state_nxt.balance = powered && balanceDemand && autoBalance && directionOk &&
			!tempLimit;

		// measurement configuration seen by the converter
		// a gain of 2 is the calibrated setting, and the one reset gives
		state_nxt.fetMode = secondThermistorFunction;
		state_nxt.gain = temperatureGainSelect ? PSO_GAIN_HIGH_SETTING :
			PSO_GAIN_LOW_SETTING;
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk) begin
		// every new field needs its reset value listed here
		if (rst) begin
			state_r.setupFirst <= PSO_SETUP_FIRST_RST;
			state_r.setupSecond <= PSO_SETUP_SECOND_RST;
			state_r.userMem <= {USER_DEPTH{PSO_USER_RST}};
			state_r.rdata <= 8'h00;
			state_r.rvalid <= 1'b0;
			state_r.cellFailSeen <= 1'b0;
			state_r.lockoutSeen <= 1'b0;
			state_r.power <= PSO_RUN;
			state_r.powerDown <= 1'b0;
			state_r.shutdown <= 1'b0;
			state_r.chargeFet <= 1'b0;
			state_r.prechargeFet <= 1'b0;
			state_r.dischargeFet <= 1'b0;
			state_r.balance <= 1'b0;
			state_r.scanStart <= 1'b0;
			state_r.fetMode <= 1'b0;
			state_r.gain <= PSO_GAIN_LOW_SETTING;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ==========================================================
	// outputs, each straight from a flip-flop
	assign regRdata = state_r.rdata;
	assign regRvalid = state_r.rvalid;
	assign packShutdownOutput = state_r.shutdown;
	assign chargeFetDrive = state_r.chargeFet;
	assign prechargeFetDrive = state_r.prechargeFet;
	assign dischargeFetDrive = state_r.dischargeFet;
	assign balanceEnable = state_r.balance;
	assign openWireScanStart = state_r.scanStart;
	// high in power-down and in the one-cycle wake check
	assign powerDownActive = state_r.powerDown;
	assign secondThermistorFetMode = state_r.fetMode;
	assign temperatureGain = state_r.gain;

endmodule : pso_setup_options
